// ### rtl/sfpf_core.sv
// Device side of the serial flash programming flow
`timescale 1ns/1ps
`default_nettype none
module sfpf_core
	import sfpf_pkg::*;
#(
	parameter int         NUM_BLOCKS = 64,
	parameter logic [3:0] REV_MAJOR  = 4'h1,
	parameter logic [3:0] REV_MINOR  = 4'h0,
	parameter logic [7:0] SILICON_ID1 = 8'h5a, // Arbitrary value
	parameter logic [7:0] SILICON_ID0 = 8'ha5, // Arbitrary value
	parameter logic [7:0] TRIM_VREF3  = 8'h80,
	parameter logic [7:0] TRIM_OSC3   = 8'h80,
	parameter logic [7:0] TRIM_VREF5  = 8'h80,
	parameter logic [7:0] TRIM_OSC5   = 8'h80,
	parameter int         BAW = $clog2(NUM_BLOCKS)
) (
	input  wire logic           sys_clk,
	input  wire logic           rstn,
	input  wire logic           link_clk,
	input  wire logic           serial_data_pin_in,
	output logic                serial_data_pin_out,
	output logic                serial_data_pin_oe_n,
	output logic                serial_data_pin_pd_en,
	input  wire logic [BAW-1:0] int_blk,
	output logic                int_wr_ok,
	output logic      [7:0]     acc_out,
	output logic      [7:0]     x_out,
	output logic                busy,
	output logic                flow_err
);
	localparam int FAW = BAW + BLK_AW;
	localparam int CW  = FAW + 1;
	localparam logic [CW-1:0] LEN_BLK = CW'(BLK_BYTES);
	localparam logic [CW-1:0] LEN_ALL = CW'(NUM_BLOCKS * BLK_BYTES);
	localparam logic [7:0]    VER     = {REV_MAJOR, REV_MINOR};

	// Link domain: runs only while the programmer clocks the pin
	sfpf_lstate_t lst_r, lst_nxt;
	logic [4:0]  lcnt_r, lcnt_nxt;
	logic [FRAME_BITS-1:0] sh_r, sh_nxt;
	sfpf_frame_t frame_r, frame_nxt;
	logic        ftgl_r, ftgl_nxt;
	logic [7:0]  tx_r, tx_nxt;
	logic        sd_m_r, sd_q_r, dn1_r, dn2_r, dn3_r;
	logic        done_tgl_r;
	logic        done_ev;
	logic [7:0]  res_r;

	assign done_ev     = dn2_r ^ dn3_r;
	assign serial_data_pin_pd_en = serial_data_pin_oe_n;

	always_comb begin
		lst_nxt    = lst_r;
		lcnt_nxt   = lcnt_r;
		sh_nxt     = sh_r;
		frame_nxt  = frame_r;
		ftgl_nxt   = ftgl_r;
		tx_nxt     = tx_r;
		serial_data_pin_out  = 1'b0;
		serial_data_pin_oe_n = 1'b1;
		case (lst_r)
			L_IDLE: begin
				// Start bit: a high level over the pulled-down idle line
				if (sd_q_r) begin
					lst_nxt  = L_RX;
					lcnt_nxt = '0;
				end
			end
			L_RX: begin
				sh_nxt   = {sh_r[FRAME_BITS-2:0], sd_q_r};
				lcnt_nxt = lcnt_r + 5'h1;
				if (lcnt_r == 5'(FRAME_BITS - 1)) begin
					frame_nxt = sh_nxt;
					ftgl_nxt  = ~ftgl_r;
					lst_nxt   = L_BUSY;
				end
			end
			L_BUSY: begin
				serial_data_pin_out  = 1'b1;
				serial_data_pin_oe_n = 1'b0;
				// Result was settled no later than the toggle moved
				if (done_ev) begin
					tx_nxt   = res_r;
					lcnt_nxt = '0;
					lst_nxt  = L_DONE;
				end
			end
			L_DONE: begin
				serial_data_pin_oe_n = 1'b0;
				lcnt_nxt   = lcnt_r + 5'h1;
				if (lcnt_r == 5'(TAIL_BITS - 1)) begin
					lcnt_nxt = '0;
					lst_nxt  = sfpf_is_read(frame_r.op) ? L_TX : L_IDLE;
				end
			end
			L_TX: begin
				serial_data_pin_out  = tx_r[7];
				serial_data_pin_oe_n = 1'b0;
				tx_nxt     = {tx_r[6:0], 1'b0};
				lcnt_nxt   = lcnt_r + 5'h1;
				if (lcnt_r == 5'(BYTE_BITS - 1)) begin
					lcnt_nxt = '0;
					lst_nxt  = L_TAIL;
				end
			end
			L_TAIL: begin
				// Low drive covers the two-stage input delay of our own bits
				serial_data_pin_oe_n = 1'b0;
				lcnt_nxt   = lcnt_r + 5'h1;
				if (lcnt_r == 5'(TAIL_BITS - 1)) begin
					lst_nxt = L_IDLE;
				end
			end
			default: lst_nxt = L_IDLE;
		endcase
	end

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			lst_r   <= L_IDLE;
			lcnt_r  <= '0;
			sh_r    <= '0;
			frame_r <= '0;
			ftgl_r  <= 1'b0;
			tx_r    <= '0;
			sd_m_r  <= 1'b0;
			sd_q_r  <= 1'b0;
			dn1_r   <= 1'b0;
			dn2_r   <= 1'b0;
			dn3_r   <= 1'b0;
		end else begin
			lst_r   <= lst_nxt;
			lcnt_r  <= lcnt_nxt;
			sh_r    <= sh_nxt;
			frame_r <= frame_nxt;
			ftgl_r  <= ftgl_nxt;
			tx_r    <= tx_nxt;
			sd_m_r  <= serial_data_pin_in;
			sd_q_r  <= sd_m_r;
			dn1_r   <= done_tgl_r;
			dn2_r   <= dn1_r;
			dn3_r   <= dn2_r;
		end
	end

	// System domain
	sfpf_sstate_t st_r, st_nxt;
	logic        f1_r, f2_r, f3_r;
	logic        cmd;
	sfpf_op_t    op_r, op_nxt;
	logic [7:0]  arg_r, arg_nxt, clk_rate_r, clk_rate_nxt, res_nxt;
	logic [7:0]  acc_r, acc_nxt, x_r, x_nxt;
	logic [BAW-1:0] blk_r, blk_nxt;
	logic [CW-1:0]  cnt_r, cnt_nxt, len_r, len_nxt, prev;
	logic [15:0] csum_r, csum_nxt;
	logic        ok_r, ok_nxt, err_r, err_nxt, done_nxt;
	logic [1:0]  prot_r [NUM_BLOCKS];
	logic [1:0]  prot_cur;
	logic        have, run_end;
	logic        fl_we, bf_we;
	logic [FAW-1:0] fl_waddr, fl_raddr;
	logic [7:0]  fl_wdata, fl_rdata, bf_wdata, bf_rdata;
	logic [BLK_AW-1:0] bf_waddr, bf_raddr;
	logic        int_wr_ok_r;
	logic [7:0]  csel;

	assign cmd      = (f2_r ^ f3_r) && st_r == S_IDLE;
	assign have     = st_r == S_RUN && cnt_r != '0;
	assign prev     = cnt_r - CW'(1);
	assign run_end  = st_r == S_RUN && cnt_r == len_r;
	assign prot_cur = prot_r[blk_r];
	assign csel     = (frame_r.arg >= 8'(NUM_BLOCKS)) ? 8'(NUM_BLOCKS - 1)
		: frame_r.arg;

	function automatic logic [7:0] slot(input logic [7:0] tbl,
		input logic [2:0] idx);
		logic [7:0] v;
		v = SLOT_RSVD;
		if (tbl == TBL_ID && idx == 3'h0) v = SILICON_ID1;
		if (tbl == TBL_ID && idx == 3'h1) v = SILICON_ID0;
		if (tbl == TBL_TRIM && idx == 3'h0) v = TRIM_VREF3;
		if (tbl == TBL_TRIM && idx == 3'h1) v = TRIM_OSC3;
		if (tbl == TBL_TRIM && idx == 3'h4) v = TRIM_VREF5;
		if (tbl == TBL_TRIM && idx == 3'h5) v = TRIM_OSC5;
		return v;
	endfunction

	always_comb begin
		st_nxt = st_r; op_nxt = op_r; arg_nxt = arg_r;
		clk_rate_nxt = clk_rate_r; res_nxt = res_r;
		acc_nxt = acc_r; x_nxt = x_r; blk_nxt = blk_r;
		cnt_nxt = cnt_r; len_nxt = len_r; csum_nxt = csum_r;
		ok_nxt = ok_r; err_nxt = err_r; done_nxt = done_tgl_r;
		// Frame fields are stable here: the link waits for our answer
		if (cmd) begin
			op_nxt  = frame_r.op;
			arg_nxt = frame_r.arg;
			cnt_nxt = '0;
			len_nxt = '0;
			ok_nxt  = 1'b1;
			err_nxt = 1'b0;
			st_nxt  = S_RUN;
			case (frame_r.op)
				OP_ID_PREP, OP_TABLE_READ: begin
					acc_nxt = VER;
					x_nxt   = (frame_r.op == OP_ID_PREP ||
						frame_r.arg == TBL_ID) ? VER : frame_r.arg;
					res_nxt = slot(frame_r.arg, frame_r.dat[2:0]);
				end
				OP_ID_READ: res_nxt = slot(TBL_ID, {2'h0, frame_r.arg[0]});
				OP_CLK_RATE: clk_rate_nxt = frame_r.arg;
				OP_SET_BLK: begin
					blk_nxt = frame_r.arg[BAW-1:0];
					err_nxt = frame_r.arg >= 8'(NUM_BLOCKS);
				end
				OP_ERASE_ALL, OP_PROTECTION_COMMIT_CMD: begin
					ok_nxt  = clk_rate_r != 8'h00;
					err_nxt = clk_rate_r == 8'h00;
					len_nxt = !ok_nxt ? '0
						: frame_r.op == OP_ERASE_ALL ? LEN_ALL : LEN_BLK;
				end
				OP_PROGRAM: begin
					ok_nxt  = !prot_cur[1] && clk_rate_r != 8'h00;
					err_nxt = !ok_nxt;
					len_nxt = ok_nxt ? LEN_BLK : '0;
				end
				OP_VERIFY: begin
					ok_nxt  = prot_cur == PROT_OPEN;
					err_nxt = !ok_nxt;
					len_nxt = LEN_BLK;
				end
				OP_RD_BYTE: len_nxt = CW'(1);
				OP_CSUM_SETUP: begin
					csum_nxt = '0;
					len_nxt  = CW'((32'(csel) + 32'd1) * BLK_BYTES);
				end
				OP_RD_CSUM: res_nxt = frame_r.arg[0] ? csum_r[7:0]
					: csum_r[15:8];
				default: ;
			endcase
		end
		if (have && op_r == OP_CSUM_SETUP) begin
			csum_nxt = csum_r + {8'h00, fl_rdata};
		end
		if (have && op_r == OP_RD_BYTE) begin
			res_nxt = bf_rdata;
		end
		if (st_r == S_RUN) begin
			cnt_nxt = cnt_r + CW'(1);
		end
		if (run_end) begin
			st_nxt   = S_IDLE;
			done_nxt = ~done_tgl_r;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= S_IDLE; op_r <= OP_NOP; arg_r <= '0;
			clk_rate_r <= '0; res_r <= '0; acc_r <= '0; x_r <= '0;
			blk_r <= '0; cnt_r <= '0; len_r <= '0; csum_r <= '0;
			ok_r <= 1'b0; err_r <= 1'b0; done_tgl_r <= 1'b0;
			f1_r <= 1'b0; f2_r <= 1'b0; f3_r <= 1'b0;
			int_wr_ok_r <= 1'b0;
		end else begin
			st_r <= st_nxt; op_r <= op_nxt; arg_r <= arg_nxt;
			clk_rate_r <= clk_rate_nxt; res_r <= res_nxt;
			acc_r <= acc_nxt; x_r <= x_nxt; blk_r <= blk_nxt;
			cnt_r <= cnt_nxt; len_r <= len_nxt; csum_r <= csum_nxt;
			ok_r <= ok_nxt; err_r <= err_nxt; done_tgl_r <= done_nxt;
			f1_r <= ftgl_r;
			f2_r <= f1_r;
			f3_r <= f2_r;
			int_wr_ok_r <= prot_r[int_blk] != PROT_FULL;
		end
	end

	// Protection table: protection_commit_cmd takes two bits per block from the buffer
	for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_prot
		logic [1:0] p_nxt;
		always_comb begin
			p_nxt = prot_r[b];
			if (have && op_r == OP_PROTECTION_COMMIT_CMD && ok_r &&
				prev[BLK_AW-1:0] == BLK_AW'(b / 4)) begin
				p_nxt = bf_rdata[(b % 4) * 2 +: 2];
			end
			if (run_end && op_r == OP_ERASE_ALL && ok_r) begin
				p_nxt = PROT_DEFAULT;
			end
		end
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				prot_r[b] <= PROT_DEFAULT;
			end else begin
				prot_r[b] <= p_nxt;
			end
		end
	end

	// Memory steering; reads lead writes by one cycle
	always_comb begin
		fl_raddr = (op_r == OP_VERIFY) ? {blk_r, cnt_r[BLK_AW-1:0]}
			: cnt_r[FAW-1:0];
		fl_we    = have && ok_r &&
			(op_r == OP_ERASE_ALL || op_r == OP_PROGRAM);
		fl_waddr = (op_r == OP_ERASE_ALL) ? prev[FAW-1:0]
			: {blk_r, prev[BLK_AW-1:0]};
		fl_wdata = (op_r == OP_ERASE_ALL) ? ERASED_BYTE : bf_rdata;
		bf_raddr = (op_r == OP_RD_BYTE) ? arg_r[BLK_AW-1:0]
			: cnt_r[BLK_AW-1:0];
		bf_we    = cmd && (frame_r.op == OP_WR_BYTE ||
			frame_r.op == OP_WR_SEC);
		bf_waddr = frame_r.arg[BLK_AW-1:0];
		bf_wdata = frame_r.dat;
		if (have && op_r == OP_VERIFY) begin
			bf_we    = 1'b1;
			bf_waddr = prev[BLK_AW-1:0];
			bf_wdata = ok_r ? fl_rdata : 8'h00;
		end
	end

	sfpf_mem #(.W(8), .D(NUM_BLOCKS * BLK_BYTES)) u_flash (
		.clk   (sys_clk),
		.rstn  (rstn),
		.we    (fl_we),
		.waddr (fl_waddr),
		.wdata (fl_wdata),
		.raddr (fl_raddr),
		.rdata (fl_rdata)
	);

	sfpf_mem #(.W(8), .D(BLK_BYTES)) u_buf (
		.clk   (sys_clk),
		.rstn  (rstn),
		.we    (bf_we),
		.waddr (bf_waddr),
		.wdata (bf_wdata),
		.raddr (bf_raddr),
		.rdata (bf_rdata)
	);

	assign int_wr_ok = int_wr_ok_r;
	assign acc_out   = acc_r;
	assign x_out     = x_r;
	assign busy      = st_r == S_RUN;
	assign flow_err  = err_r;

	property p_ver_acc;
		@(posedge sys_clk) disable iff (!rstn)
		cmd && frame_r.op == OP_TABLE_READ |=> acc_r == VER
			&& acc_out[7:4] == REV_MAJOR;
	endproperty
	a_ver_acc: assert property (p_ver_acc) else $error("bad version");

	property p_x_mod;
		@(posedge sys_clk) disable iff (!rstn)
		cmd && frame_r.op == OP_TABLE_READ && frame_r.arg != TBL_ID
			|=> x_r == $past(frame_r.arg);
	endproperty
	a_x_mod: assert property (p_x_mod) else $error("x not set");

	property p_id_read;
		@(posedge sys_clk) disable iff (!rstn)
		cmd && frame_r.op == OP_ID_READ && !frame_r.arg[0]
			|=> res_r == SILICON_ID1;
	endproperty
	a_id_read: assert property (p_id_read) else $error("bad id");

	property p_prog_gate;
		@(posedge sys_clk) disable iff (!rstn)
		fl_we && op_r == OP_PROGRAM |-> !prot_cur[1];
	endproperty
	a_prog_gate: assert property (p_prog_gate)
		else $error("write to guarded block");

	property p_rd_gate;
		@(posedge sys_clk) disable iff (!rstn)
		have && op_r == OP_VERIFY && prot_cur != PROT_OPEN
			|-> bf_wdata == 8'h00;
	endproperty
	a_rd_gate: assert property (p_rd_gate)
		else $error("read of guarded block");

	property p_default;
		@(posedge sys_clk) disable iff (!rstn)
		run_end && op_r == OP_ERASE_ALL && ok_r
			|=> prot_r[0] == PROT_DEFAULT
			&& prot_r[NUM_BLOCKS-1] == PROT_DEFAULT ##1 int_wr_ok;
	endproperty
	a_default: assert property (p_default)
		else $error("no default protection");

	property p_pulldown;
		@(posedge link_clk) disable iff (!rstn)
		lst_r == L_IDLE |-> serial_data_pin_oe_n && serial_data_pin_pd_en;
	endproperty
	a_pulldown: assert property (p_pulldown)
		else $error("idle pin not pulled");

	property p_done_fall;
		@(posedge link_clk) disable iff (!rstn)
		lst_r == L_BUSY && serial_data_pin_out && done_ev
			|=> !serial_data_pin_out && !serial_data_pin_oe_n ##1 !serial_data_pin_out;
	endproperty
	a_done_fall: assert property (p_done_fall)
		else $error("no falling edge");

	c_erase: cover property (@(posedge sys_clk) disable iff (!rstn)
		run_end && op_r == OP_ERASE_ALL);
	c_program: cover property (@(posedge sys_clk) disable iff (!rstn)
		fl_we && op_r == OP_PROGRAM);
	c_protection_commit_cmd: cover property (@(posedge sys_clk) disable iff (!rstn)
		run_end && op_r == OP_PROTECTION_COMMIT_CMD && ok_r);
	c_tx: cover property (@(posedge link_clk) disable iff (!rstn)
		lst_r == L_TX);
endmodule
`default_nettype wire

// ### rtl/sfpf_mem.sv
// Simple dual-port byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module sfpf_mem #(
	parameter int W = 8,
	parameter int D = 64,
	parameter int AW = $clog2(D)
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);
	logic [W-1:0] mem [D];

	// Array kept without reset so it maps onto block memory
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule
`default_nettype wire

// ### rtl/sfpf_pkg.sv
// Shared types and constants of the serial flash programming flow
`default_nettype none
package sfpf_pkg;
	localparam int BLK_BYTES = 64;
	localparam int BLK_AW    = 6;
	localparam int CMD_W     = 4;

	// Command opcodes carried in each frame
	typedef enum logic [CMD_W-1:0] {
		OP_NOP        = 4'h0,
		OP_ID_PREP    = 4'h1,
		OP_ID_READ    = 4'h2,
		OP_CLK_RATE   = 4'h3,
		OP_ERASE_ALL  = 4'h4,
		OP_WR_BYTE    = 4'h5,
		OP_SET_BLK    = 4'h6,
		OP_PROGRAM    = 4'h7,
		OP_VERIFY     = 4'h8,
		OP_RD_BYTE    = 4'h9,
		OP_WR_SEC     = 4'ha,
		OP_PROTECTION_COMMIT_CMD     = 4'hb,
		OP_CSUM_SETUP = 4'hc,
		OP_RD_CSUM    = 4'hd,
		OP_TABLE_READ = 4'he
	} sfpf_op_t;

	typedef struct packed {
		sfpf_op_t    op;
		logic [7:0]  arg;
		logic [7:0]  dat;
	} sfpf_frame_t;

	localparam int FRAME_BITS = $bits(sfpf_frame_t);
	localparam int TAIL_BITS  = 2;
	localparam int BYTE_BITS  = 8;

	localparam logic [1:0] PROT_OPEN    = 2'h0;
	localparam logic [1:0] PROT_NO_RD   = 2'h1;
	localparam logic [1:0] PROT_NO_RDWR = 2'h2;
	localparam logic [1:0] PROT_FULL    = 2'h3;
	localparam logic [1:0] PROT_DEFAULT = PROT_NO_RDWR;

	localparam logic [7:0] TBL_ID      = 8'h00;
	localparam logic [7:0] TBL_TRIM    = 8'h01;
	localparam logic [7:0] SLOT_RSVD   = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'h00;

	typedef enum logic [5:0] {
		L_IDLE = 6'h01,
		L_RX   = 6'h02,
		L_BUSY = 6'h04,
		L_DONE = 6'h08,
		L_TX   = 6'h10,
		L_TAIL = 6'h20
	} sfpf_lstate_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'h1,
		S_RUN  = 2'h2
	} sfpf_sstate_t;

	function automatic logic sfpf_is_read(input sfpf_op_t op);
		return op == OP_ID_READ || op == OP_RD_BYTE ||
			op == OP_RD_CSUM || op == OP_TABLE_READ;
	endfunction
endpackage
`default_nettype wire

// ### test/sfpf_prog_model.sv
// Programmer model: drives the serial clock and the data pin
`timescale 1ns/1ps
`default_nettype none
module sfpf_prog_model
	import sfpf_pkg::*;
(
	output logic      link_clk,
	output logic      serial_data_pin_in,
	input  wire logic serial_data_pin_out,
	input  wire logic serial_data_pin_oe_n,
	input  wire logic serial_data_pin_pd_en
);
	logic clk_on;
	logic drv_en;
	logic drv_val;
	logic last_pin;

	initial begin
		clk_on = 1'b0;
		drv_en = 1'b0; // Data pin floats at power-up
		drv_val = 1'b0;
		last_pin = 1'b0;
		link_clk = 1'b0; // Clock held low at power-up
		#3.3;
		forever begin
			#7.5;
			link_clk = clk_on ? ~link_clk : 1'b0; // Runs free once on
		end
	end

	always @(negedge link_clk)
		last_pin <= serial_data_pin_in;

	// Released pin falls to the pull-down; without it, the inverse of the last sampled level
	assign serial_data_pin_in = !serial_data_pin_oe_n ? serial_data_pin_out : drv_en ? drv_val :
		serial_data_pin_pd_en ? 1'b0 : ~last_pin;

	task automatic power_up();
		#30;
		clk_on = 1'b1; // Clock starts free running
	endtask

	task automatic power_down();
		@(negedge link_clk);
		drv_en = 1'b0; // Float data first
		@(negedge link_clk);
		clk_on = 1'b0; // Then clock low
	endtask

	task automatic xfer(input sfpf_frame_t f, output logic [7:0] rd,
		output logic ok);
		logic [FRAME_BITS:0] sh;
		int n;
		sh = {1'b1, f};
		rd = 8'h00;
		n = 0;
		for (int i = FRAME_BITS; i >= 0; i--) begin
			@(negedge link_clk);
			drv_en = 1'b1;
			drv_val = sh[i];
		end
		@(negedge link_clk);
		drv_en = 1'b0;
		while (serial_data_pin_oe_n && n < 40) begin
			@(negedge link_clk);
			n++;
		end
		while (serial_data_pin_in && n < 20000) begin
			@(negedge link_clk);
			n++;
		end
		ok = !serial_data_pin_oe_n && n < 20000; // Done is the falling pin
		if (sfpf_is_read(f.op)) begin
			@(negedge link_clk);
			for (int i = 0; i < BYTE_BITS; i++) begin
				@(negedge link_clk);
				rd = {rd[6:0], serial_data_pin_in};
			end
		end
		n = 0;
		while (!serial_data_pin_oe_n && n < 8) begin
			@(negedge link_clk);
			n++;
		end
		ok = ok && serial_data_pin_oe_n; // Next frame only once released
		@(negedge link_clk);
	endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench of the device side of the programming flow
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sfpf_pkg::*;
	localparam int         NB   = 4;
	localparam logic [7:0] ID1  = 8'h3c; // Arbitrary value
	localparam logic [7:0] ID0  = 8'hc3; // Arbitrary value
	localparam logic [7:0] VER  = 8'h37;
	localparam logic [7:0] RATE = 8'hc8; // Byte-sized rate value

	logic       sys_clk;
	logic       rstn;
	logic       link_clk;
	logic       serial_data_pin_in;
	logic       serial_data_pin_out;
	logic       serial_data_pin_oe_n;
	logic       serial_data_pin_pd_en;
	logic [1:0] int_blk;
	logic       int_wr_ok;
	logic [7:0] acc_out;
	logic [7:0] x_out;
	logic       busy;
	logic       flow_err;
	logic [7:0] rd;
	logic [7:0] sec0;
	logic [7:0] mem [NB][BLK_BYTES];
	logic [15:0] sum;
	int         bad_count;
	int         num_checks;

	sfpf_core #(.NUM_BLOCKS(NB), .REV_MAJOR(VER[7:4]), .REV_MINOR(VER[3:0]),
		.SILICON_ID1(ID1), .SILICON_ID0(ID0), .TRIM_VREF3(8'h11),
		.TRIM_OSC3(8'h22), .TRIM_VREF5(8'h33), .TRIM_OSC5(8'h44)) u_sfpf_core (
		.sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk),
		.serial_data_pin_in(serial_data_pin_in), .serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe_n(serial_data_pin_oe_n),
		.serial_data_pin_pd_en(serial_data_pin_pd_en), .int_blk(int_blk), .int_wr_ok(int_wr_ok),
		.acc_out(acc_out), .x_out(x_out), .busy(busy), .flow_err(flow_err));

	sfpf_prog_model u_sfpf_prog_model (.link_clk(link_clk),
		.serial_data_pin_in(serial_data_pin_in), .serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe_n(serial_data_pin_oe_n),
		.serial_data_pin_pd_en(serial_data_pin_pd_en));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	function automatic logic [7:0] exp_slot(input logic t, input int s);
		case ({t, s[2:0]})
			4'h0: return ID1;
			4'h1: return ID0;
			4'h8: return 8'h11;
			4'h9: return 8'h22;
			4'hc: return 8'h33;
			4'hd: return 8'h44;
			default: return 8'h00; // Reserved slots
		endcase
	endfunction

	function automatic logic [1:0] prot(input int b);
		return sec0[2*b +: 2];
	endfunction

	task automatic check(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			bad_count++;
		end
	endtask

	task automatic run(input sfpf_op_t op, input logic [7:0] arg,
		input logic [7:0] dat);
		logic ok;
		u_sfpf_prog_model.xfer(sfpf_frame_t'{op, arg, dat}, rd, ok);
		check("frame_done", 16'h1, {15'h0, ok});
		check("busy_done", 16'h0, {15'h0, busy});
		repeat (3) @(negedge sys_clk);
	endtask

	task automatic give_verdict();
		if (bad_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Limit is about one and a half times the expected run
	initial begin
		repeat (90000) @(posedge sys_clk);
		bad_count++;
		give_verdict();
	end

	initial begin
		rstn = 1'b0;
		int_blk = 2'h0;
		bad_count = 0;
		num_checks = 0;
		void'($urandom(22));
		u_sfpf_prog_model.power_up();
		repeat (8) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (5) @(negedge sys_clk);
		check("pin_idle", 16'h0001, {15'h0, serial_data_pin_in ^ 1'b1});
		check("pull_down", 16'h0001, {15'h0, serial_data_pin_pd_en});
		for (int b = 0; b < NB; b++) begin
			int_blk = b[1:0];
			repeat (3) @(negedge sys_clk);
			check("int_wr_dflt", 16'h1, {15'h0, int_wr_ok});
		end
		run(OP_ID_PREP, 8'h00, 8'h00);
		run(OP_ID_READ, 8'h00, 8'h00);
		check("id1", {8'h00, ID1}, {8'h00, rd});
		run(OP_ID_READ, 8'h01, 8'h00);
		check("id0", {8'h00, ID0}, {8'h00, rd});
		for (int t = 0; t < 2; t++) begin
			for (int s = 0; s < 8; s++) begin
				run(OP_TABLE_READ, t[7:0], s[7:0]);
				check("table_slot", {8'h00, exp_slot(t[0], s)}, {8'h00, rd});
				check("acc_ver", {8'h00, VER}, {8'h00, acc_out});
			end
		end
		check("x_clobber", 16'h0001, {8'h00, x_out});
		run(OP_ERASE_ALL, 8'h00, 8'h00);
		check("erase_no_rate", 16'h1, {15'h0, flow_err});
		run(OP_CLK_RATE, RATE, 8'h00);
		run(OP_ERASE_ALL, 8'h00, 8'h00);
		check("erase_ok", 16'h0, {15'h0, flow_err});
		sec0 = 8'b11_10_01_00; // Every code on one block each
		for (int k = 0; k < BLK_BYTES; k++) begin
			run(OP_WR_SEC, k[7:0], (k == 0) ? sec0 : 8'($urandom));
		end
		run(OP_CLK_RATE, RATE, 8'h00);
		run(OP_PROTECTION_COMMIT_CMD, 8'h00, 8'h00);
		check("protection_commit_cmd_ok", 16'h0, {15'h0, flow_err});
		for (int b = 0; b < NB; b++) begin
			int_blk = b[1:0];
			repeat (3) @(negedge sys_clk);
			check("int_wr", {15'h0, prot(b) != 2'b11}, {15'h0, int_wr_ok});
		end
		sum = 16'h0000;
		for (int b = 0; b < NB; b++) begin
			for (int a = 0; a < BLK_BYTES; a++) begin
				mem[b][a] = 8'($urandom);
				run(OP_WR_BYTE, a[7:0], mem[b][a]);
				if (prot(b) >= 2'b10)
					mem[b][a] = ERASED_BYTE;
				sum = sum + {8'h00, mem[b][a]};
			end
			run(OP_CLK_RATE, RATE, 8'h00);
			run(OP_SET_BLK, b[7:0], 8'h00);
			run(OP_PROGRAM, 8'h00, 8'h00);
			check("prog_err", {15'h0, prot(b) >= 2'b10}, {15'h0, flow_err});
		end
		// Two passes stand for the low and high supply verifies
		for (int pass = 0; pass < 2; pass++) begin
			for (int b = 0; b < NB; b++) begin
				run(OP_SET_BLK, b[7:0], 8'h00);
				run(OP_VERIFY, 8'h00, 8'h00);
				check("verify_err", {15'h0, prot(b) != 2'b00},
					{15'h0, flow_err});
				for (int a = 0; a < BLK_BYTES; a++) begin
					run(OP_RD_BYTE, a[7:0], 8'h00);
					check("rd_byte",
						{8'h00, (prot(b) == 2'b00) ? mem[b][a] : 8'h00},
						{8'h00, rd});
				end
			end
		end
		run(OP_CSUM_SETUP, 8'(NB - 1), 8'h00);
		run(OP_RD_CSUM, 8'h01, 8'h00);
		check("csum_lo", {8'h00, sum[7:0]}, {8'h00, rd});
		run(OP_RD_CSUM, 8'h00, 8'h00);
		check("csum_hi", {8'h00, sum[15:8]}, {8'h00, rd});
		run(OP_SET_BLK, 8'(NB), 8'h00);
		check("blk_range", 16'h1, {15'h0, flow_err});
		u_sfpf_prog_model.power_down();
		repeat (5) @(negedge sys_clk);
		give_verdict();
	end
endmodule
`default_nettype wire
